//--- fhp_host.sv
`timescale 1ns/1ns
`default_nettype none
module fhp_host
	import fhp_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             chip_en_n_o,
	output logic             write_en_n_o,
	output logic             out_en_n_o,
	output logic [12:0]      addr_o,
	output logic [15:0]      data_o,
	output logic             data_oe_o,
	input  wire logic [15:0] data_i,
	output logic             address_valid_strobe_n_o,
	output logic             device_select_bit_low_o,
	output logic             width_cfg_o,
	output logic             deep_power_down_ctl_o,
	output logic             lock_n_o,
	output logic             reset_input_n_o,
	input  wire logic        busy_n_i,
	input  wire logic        irq_n_i,
	input  wire logic        dma_request_n_i
);
	fhp_cyc_if cyc();
	logic [31:0] ctrl_q;
	logic [12:0] addr_q;
	logic [15:0] wdata_q;
	logic        start_q;
	logic        busy_q;
	logic        mux_q;
	logic        irq_seen_q;
	logic        dma_seen_q;
	logic [2:0]  sel_phase_q;
	logic        idle_vld_n_q;
	logic        sel_done;
	logic        go_req;
	logic        go_ok;
	logic [31:0] status_w;
	logic        wr_acc;
	logic        rd_acc;
	logic        clr_irq;
	logic        clr_dma;
	logic [31:0] rd_mux;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign clr_irq = wr_acc && paddr == REG_STATUS && pwdata[2];
	assign clr_dma = wr_acc && paddr == REG_STATUS && pwdata[3];
	assign cyc.start = start_q;
	assign cyc.write = ctrl_q[CTRL_WRITE];
	assign cyc.mux   = mux_q;
	assign cyc.addr  = addr_q;
	assign cyc.wdata = wdata_q;
	// idle select level rides the sequencer flop, so the edge and address phase share one output
	assign cyc.idle_vld_n = idle_vld_n_q;
	assign sel_done  = sel_phase_q == 3'(SEL_PHASES);
	// go is dropped silently when sequencer or device is busy, or the select edge is still due
	assign go_req    = wr_acc && pready && paddr == REG_CTRL && pwdata[CTRL_GO];
	assign go_ok     = go_req && !busy_q && busy_n_i && (sel_done || !ctrl_q[CTRL_MUX]);

	fhp_seq u_seq (
		.core_clk_i   (core_clk_i),
		.nrst_i       (nrst_i),
		.cyc          (cyc),
		.data_in_i    (data_i),
		.chip_en_n_q  (chip_en_n_o),
		.write_en_n_q (write_en_n_o),
		.out_en_n_q   (out_en_n_o),
		.addr_vld_n_q (address_valid_strobe_n_o),
		.addr_q       (addr_o),
		.data_out_q   (data_o),
		.data_oe_q    (data_oe_o)
	);

	// apb slave: zero wait, unmapped reads zero, offsets above status flag error
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > REG_STATUS;
			prdata <= rd_mux;
		end
	end

	// status word; busy and dma request pins read live, they are taken as synchronous
	always_comb begin
		status_w    = '0;
		status_w[0] = busy_q;
		status_w[1] = ~dma_request_n_i;
		status_w[2] = irq_seen_q;
		status_w[3] = dma_seen_q;
		status_w[4] = ~busy_n_i;
		status_w[5] = mux_q;
	end

	always_comb begin
		if (paddr == REG_CTRL)
			rd_mux = ctrl_q;
		else if (paddr == REG_ADDR)
			rd_mux = {19'h0, addr_q};
		else if (paddr == REG_WDATA)
			rd_mux = {16'h0, wdata_q};
		else if (paddr == REG_RDATA)
			rd_mux = {16'h0, cyc.rdata};
		else if (paddr == REG_STATUS)
			rd_mux = status_w;
		else
			rd_mux = '0;
	end

	// writes take effect at the access edge; pready high then (no wait)
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= CTRL_RESET;
			addr_q <= '0;
			wdata_q <= '0;
		end else if (wr_acc && pready) begin
			if (paddr == REG_CTRL)
				ctrl_q <= pwdata & 32'h0000_00FE;
			else if (paddr == REG_ADDR)
				addr_q <= pwdata[12:0];
			else if (paddr == REG_WDATA)
				wdata_q <= pwdata[15:0];
		end
	end

	// cycle launch; refused while device busy or after no edge in mux mode
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (cyc.done)
				busy_q <= 1'b0;
			else if (go_ok) begin
				start_q <= 1'b1;
				busy_q <= 1'b1;
			end
		end
	end

	// mode edge: once the ctrl mux bit is set and the device is not busy, pulse select low for one cycle once, then hold it high
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel_phase_q <= 3'h0;
			idle_vld_n_q <= 1'b1;
			mux_q <= 1'b0;
		end else if (ctrl_q[CTRL_MUX] && !sel_done && busy_n_i) begin
			// counter parks at its end value, so the edge is made once per reset
			sel_phase_q <= sel_phase_q + 3'h1;
			if (sel_phase_q == 3'(SEL_PHASES - 1)) begin
				idle_vld_n_q <= 1'b0;
				mux_q <= 1'b1;
			end
		end else if (sel_done) begin
			idle_vld_n_q <= 1'b1;
		end
	end

	// sticky event capture, set wins over clear
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_seen_q <= 1'b0;
			dma_seen_q <= 1'b0;
		end else begin
			irq_seen_q <= !irq_n_i || (irq_seen_q && !clr_irq);
			dma_seen_q <= !dma_request_n_i || (dma_seen_q && !clr_dma);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			device_select_bit_low_o <= 1'b0;
			width_cfg_o <= 1'b1;
			deep_power_down_ctl_o <= 1'b0;
			lock_n_o <= 1'b1;
			reset_input_n_o <= 1'b0;
		end else begin
			device_select_bit_low_o <= ctrl_q[CTRL_DEV];
			width_cfg_o <= ctrl_q[CTRL_WIDE];
			deep_power_down_ctl_o <= ctrl_q[CTRL_PD];
			lock_n_o <= ~ctrl_q[CTRL_LOCK];
			reset_input_n_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- fhp_pkg.sv
package fhp_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// ctrl fields
	localparam int CTRL_GO    = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_MUX   = 2;
	localparam int CTRL_WIDE  = 3;
	localparam int CTRL_PD    = 4;
	localparam int CTRL_LOCK  = 5;
	localparam int CTRL_DEV   = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
	// strobe timing
	localparam int STROBE_NS  = 60;
	localparam int CLK_NS     = 20;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEL_PHASES = 3;
	localparam int CNT_W      = 8;
endpackage

//--- fhp_cyc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fhp_cyc_if;
	logic                  start;
	logic                  write;
	logic                  mux;
	logic [12:0]           addr;
	logic [15:0]           wdata;
	logic [15:0]           rdata;
	logic                  done;
	logic                  idle_vld_n;
	modport ctl (output start, output write, output mux, output addr, output wdata, output idle_vld_n,
		input rdata, input done);
	modport seq (input start, input write, input mux, input addr, input wdata, input idle_vld_n,
		output rdata, output done);
endinterface
`default_nettype wire

//--- fhp_seq.sv
`timescale 1ns/1ns
`default_nettype none
module fhp_seq
	import fhp_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	fhp_cyc_if.seq           cyc,
	input  wire logic [15:0] data_in_i,
	output logic             chip_en_n_q,
	output logic             write_en_n_q,
	output logic             out_en_n_q,
	output logic             addr_vld_n_q,
	output logic [12:0]      addr_q,
	output logic [15:0]      data_out_q,
	output logic             data_oe_q
);
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_STROBE, S_DONE} fhp_seq_st_t;
	fhp_seq_st_t     st_q;
	logic [CNT_W-1:0] cnt_q;
	logic             wr_q;
	logic [15:0]      rdata_q;
	logic             done_q;
	assign cyc.rdata = rdata_q;
	assign cyc.done  = done_q;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= S_IDLE;
			cnt_q <= '0;
			wr_q <= 1'b0;
			chip_en_n_q <= 1'b1;
			write_en_n_q <= 1'b1;
			out_en_n_q <= 1'b1;
			addr_vld_n_q <= 1'b1;
			addr_q <= '0;
			data_out_q <= '0;
			data_oe_q <= 1'b0;
			rdata_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				S_IDLE: begin
					// idle level comes from the host so select edge and address phase share this flop
					addr_vld_n_q <= cyc.idle_vld_n;
					if (cyc.start) begin
						wr_q <= cyc.write;
						addr_q <= cyc.addr;
						cnt_q <= CNT_W'(STROBE_CYC);
						chip_en_n_q <= 1'b0;
						if (cyc.mux) begin
							// address bits 12:1 on low lines, top four zero
							data_out_q <= {4'h0, cyc.addr[12:1]};
							data_oe_q <= 1'b1;
							addr_vld_n_q <= 1'b0;
							st_q <= S_ADDR;
						end else begin
							data_out_q <= cyc.wdata;
							data_oe_q <= cyc.write;
							write_en_n_q <= ~cyc.write;
							out_en_n_q <= cyc.write;
							st_q <= S_STROBE;
						end
					end
				end
				S_ADDR: begin
					addr_vld_n_q <= 1'b1;
					data_out_q <= cyc.wdata;
					data_oe_q <= wr_q;
					write_en_n_q <= ~wr_q;
					out_en_n_q <= wr_q;
					st_q <= S_STROBE;
				end
				S_STROBE: begin
					if (cnt_q <= CNT_W'(1)) begin
						// sample before release so data is still driven
						if (!wr_q)
							rdata_q <= data_in_i;
						chip_en_n_q <= 1'b1;
						write_en_n_q <= 1'b1;
						out_en_n_q <= 1'b1;
						st_q <= S_DONE;
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				S_DONE: begin
					data_oe_q <= 1'b0;
					done_q <= 1'b1;
					st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- fhp_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fhp_chk (
	input wire logic        core_clk_i,
	input wire logic        nrst_i,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        chip_en_n_o,
	input wire logic        write_en_n_o,
	input wire logic        out_en_n_o,
	input wire logic        data_oe_o,
	input wire logic [15:0] data_o,
	input wire logic        address_valid_strobe_n_o,
	input wire logic        reset_input_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence wr_s; !write_en_n_o [*3] ##1 write_en_n_o; endsequence
	sequence rd_s; !out_en_n_o [*3] ##1 out_en_n_o; endsequence
	rdy_once_a: assert property (pready |=> !pready) else $error("pready held");
	rdy_wait_a: assert property (psel && !penable |=> pready) else $error("pready late");
	wr_len_a: assert property ($fell(write_en_n_o) |-> wr_s) else $error("write strobe width");
	rd_len_a: assert property ($fell(out_en_n_o) |-> rd_s) else $error("read strobe width");
	wr_pair_a: assert property (!write_en_n_o |-> !chip_en_n_o && data_oe_o && out_en_n_o)
		else $error("write without select");
	rd_pair_a: assert property (!out_en_n_o |-> !chip_en_n_o && !data_oe_o)
		else $error("read without select");
	mux_adr_a: assert property (!address_valid_strobe_n_o && !chip_en_n_o |-> data_oe_o && data_o[15:12] == 4'h0)
		else $error("bad address phase");
	rst_idle_a: assert property (!reset_input_n_o |-> chip_en_n_o && address_valid_strobe_n_o)
		else $error("access in reset");
endmodule
bind fhp_host fhp_chk chk (.core_clk_i, .nrst_i, .psel, .penable, .pready, .chip_en_n_o, .write_en_n_o,
	.out_en_n_o, .data_oe_o, .data_o, .address_valid_strobe_n_o, .reset_input_n_o);
`default_nettype wire

//--- fhp_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module fhp_dev_model #(
	parameter logic [12:0] PROT_BASE = 13'h1000,
	parameter logic [7:0]  BUSY_CYC  = 8'h14
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic [12:0] addr_i,
	input  wire logic [15:0] bus_i,
	input  wire logic        addr_vld_n_i,
	input  wire logic        lock_n_i,
	input  wire logic        ev_i,
	output logic [15:0]      bus_o,
	output logic             busy_n_o,
	output logic             irq_n_o,
	output logic             dma_n_o
);
	logic [15:0] mem [8192];
	logic [15:0] last_q;
	logic [11:0] lat_q;
	logic [7:0]  bc_q;
	logic        mux_q;
	logic        viol_q;
	logic        dead_q;
	wire  [12:0] a   = mux_q ? {lat_q, 1'b0} : addr_i;
	wire         drv = !ce_n_i && !oe_n_i;
	wire         wr  = !ce_n_i && !we_n_i;
	wire         ok  = !dead_q && (lock_n_i || a < PROT_BASE);
	// released bus shows inverted last value, so a stale sample cannot pass
	assign bus_o = drv ? mem[a] : ~last_q;
	assign busy_n_o = bc_q == BUSY_CYC;
	assign irq_n_o = !(ev_i || viol_q);
	assign dma_n_o = !ev_i;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bc_q <= 8'h00;
			viol_q <= 1'b0;
			dead_q <= 1'b0;
		end else begin
			if (bc_q != BUSY_CYC)
				bc_q <= bc_q + 8'h01;
			if (wr && !ok) begin
				viol_q <= 1'b1;
				// a write past the lock counts as tampering and seals the array until reset
				dead_q <= 1'b1;
			end
		end
	end
	always @(negedge addr_vld_n_i or negedge rst_n_i) begin
		if (!rst_n_i)
			mux_q <= 1'b0;
		else
			mux_q <= 1'b1;
	end
	always @(posedge clk_i) begin
		if (mux_q && !addr_vld_n_i && !ce_n_i)
			lat_q <= bus_i[11:0];
		if (drv)
			last_q <= mem[a];
		if (wr && ok)
			mem[a] <= bus_i;
	end
endmodule
`default_nettype wire

//--- fhp_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fhp_host_tb_top;
	import fhp_pkg::*;
	logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, ev = 0, err, pslverr, pready;
	logic        ce_n, we_n, oe_n, doe, vld_n, dsel, wcfg, pd, lock_n, rin_n, busy_n, irq_n, dma_n;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv, cfg = 32'h8;
	logic [12:0] addr;
	logic [15:0] dout, din;
	int          err_total = 0, comparisons = 0;
	always #10 clk = ~clk;
	fhp_host dut (.core_clk_i(clk), .nrst_i(nrst), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .chip_en_n_o(ce_n), .write_en_n_o(we_n), .out_en_n_o(oe_n), .addr_o(addr), .data_o(dout),
		.data_oe_o(doe), .data_i(din), .address_valid_strobe_n_o(vld_n), .device_select_bit_low_o(dsel),
		.width_cfg_o(wcfg), .deep_power_down_ctl_o(pd), .lock_n_o(lock_n), .reset_input_n_o(rin_n),
		.busy_n_i(busy_n), .irq_n_i(irq_n), .dma_request_n_i(dma_n));
	fhp_dev_model dev (.clk_i(clk), .rst_n_i(rin_n), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr),
		.bus_i(dout), .addr_vld_n_i(vld_n), .lock_n_i(lock_n), .ev_i(ev), .bus_o(din), .busy_n_o(busy_n),
		.irq_n_o(irq_n), .dma_n_o(dma_n));
	task automatic stop_test;
		$display("checked %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// one apb transfer; an idle edge after it keeps psel from being set twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic poll(input int b);
		rv = 32'hFFFF_FFFF;
		for (int n = 0; n < 60 && rv[b] !== 1'b0; n++)
			apb(1'b0, REG_STATUS, 32'h0);
		cmp("status bit clear", 32'h0, {31'h0, rv[b]});
	endtask
	task automatic op(input logic w, input logic [12:0] a, input logic [15:0] d);
		apb(1'b1, REG_ADDR, {19'h0, a});
		apb(1'b1, REG_WDATA, {16'h0, d});
		apb(1'b1, REG_CTRL, cfg | {30'h0, w, 1'b1});
		poll(0);
		apb(1'b0, REG_RDATA, 32'h0);
	endtask
	initial begin
		#400000;
		err_total++;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge clk);
		cmp("idle pins", 32'hE, {28'h0, ce_n, we_n, oe_n, rin_n});
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, REG_CTRL, 32'h0);
		cmp("ctrl reset", CTRL_RESET, rv);
		cmp("width pin", 32'h1, {31'h0, wcfg});
		poll(4);
		$display("reset test done");
		op(1'b1, 13'h1FFF, 16'hA55A);
		op(1'b1, 13'h0000, 16'h5AA5);
		op(1'b0, 13'h1FFF, 16'h0);
		cmp("top word", 32'hA55A, rv);
		op(1'b0, 13'h0000, 16'h0);
		cmp("bottom word", 32'h5AA5, rv);
		$display("access test done");
		ev <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp("event flags", 32'hE, rv & 32'h2E);
		ev <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b1, REG_STATUS, 32'hC);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp("flags cleared", 32'h0, rv & 32'h2E);
		apb(1'b1, REG_CTRL, cfg | 32'h50);
		@(posedge clk);
		cmp("pd and id pins", 32'h3, {30'h0, pd, dsel});
		apb(1'b0, 8'h14, 32'h0);
		cmp("unmapped", 32'h1, {31'h0, err});
		$display("pin test done");
		cfg = 32'h28;
		apb(1'b1, REG_CTRL, cfg);
		@(posedge clk);
		cmp("lock pin", 32'h0, {31'h0, lock_n});
		op(1'b1, 13'h1FFF, 16'h1234);
		op(1'b0, 13'h1FFF, 16'h0);
		cmp("locked word", 32'hA55A, rv);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp("violation flag", 32'h4, rv & 32'h4);
		op(1'b1, 13'h0000, 16'hFFFF);
		$display("lock test done");
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		cmp("reset pins", 32'hE, {28'h0, ce_n, we_n, oe_n, rin_n});
		nrst <= 1'b1;
		@(posedge clk);
		poll(4);
		cfg = 32'h08;
		op(1'b0, 13'h0000, 16'h0);
		cmp("sealed word", 32'h5AA5, rv);
		$display("seal test done");
		cfg = 32'h0C;
		apb(1'b1, REG_CTRL, cfg);
		repeat (4) @(posedge clk);
		op(1'b1, 13'h0ABC, 16'hC3C3);
		op(1'b0, 13'h0ABC, 16'h0);
		cmp("mux word", 32'hC3C3, rv);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp("mux active", 32'h20, rv & 32'h20);
		$display("mux test done");
		stop_test;
	end
endmodule
`default_nettype wire
